// *** design/rcs_defines.svh ***
// constants for the reset and clock source control block
`ifndef RCS_DEFINES_SVH
`define RCS_DEFINES_SVH
`define RCS_CLK_PERIOD_NS 25
`define RCS_RST_HOLD_NS 1000
`define RCS_RST_HOLD_CYC ((`RCS_RST_HOLD_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)
`define RCS_CLK_GAP_NS 100
`define RCS_CLK_GAP_CYC ((`RCS_CLK_GAP_NS + `RCS_CLK_PERIOD_NS - 1) / `RCS_CLK_PERIOD_NS)
`define RCS_CAUSE_POR 0
`define RCS_CAUSE_BOR 2
`define RCS_CAUSE_WDT 3
`define RCS_CAUSE_SW 4
`define RCS_CAUSE_RESET 5'h01
`define RCS_OSC_MAIN 2'h0
`define RCS_OSC_INT 2'h1
`define RCS_OSC_INT4 2'h2
`define RCS_OSC_30K 2'h3
`define RCS_EXT_RTC 3'h7
`define RCS_CLK_CFG_RESET 7'h50
`define RCS_TRIM_RESET 8'h00
`define RCS_TRIM_MAX_UP 8'sh05
`define RCS_TRIM_MAX_DN (-8'sh05)
`define RCS_PRST_RESET 32'h0
`define RCS_WDT_RESET 32'hFFFF_FFFF
`endif

// *** design/rcs_pkg.sv ***
// types of the reset and clock source control block
package rcs_pkg;
   typedef enum logic [2:0] {
      RCS_SRC_INT   = 3'h0,
      RCS_SRC_INT4  = 3'h1,
      RCS_SRC_MAIN  = 3'h2,
      RCS_SRC_30K   = 3'h3,
      RCS_SRC_RTC   = 3'h4,
      RCS_SRC_PLL   = 3'h5
   } rcs_src_e;
   typedef enum logic [1:0] {
      RCS_ST_IDLE    = 2'b00,
      RCS_ST_ASSERT  = 2'b01,
      RCS_ST_STRETCH = 2'b11,
      RCS_ST_BOOT    = 2'b10
   } rcs_rst_st_e;
   typedef struct packed {
      logic       bypass;
      logic [1:0] osc_source_select;
      logic       use_ext;
      logic [2:0] extended_osc_source_select;
   } rcs_clk_cfg_s;
   typedef struct packed {
      logic [95:0] run;
      logic [95:0] slp;
      logic [95:0] dslp;
   } rcs_prst_s;
   typedef logic [4:0] rcs_cause_t;
endpackage

// *** design/rcs_top.sv ***
// reset sequencing, reset cause, watchdog, regulator trim and clock source select
`include "rcs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rcs_top (
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire logic                  bor_low,
   input  wire logic                  bor_ctl_wr,
   input  wire logic                  bor_ctl_wdata,
   input  wire logic                  system_reset_request,
   input  wire logic [2:0]            prst_wr,
   input  wire logic [31:0]           prst_wdata,
   input  wire logic                  trim_wr,
   input  wire logic [7:0]            trim_wdata,
   input  wire logic                  clk_cfg_wr,
   input  wire rcs_pkg::rcs_clk_cfg_s clk_cfg_wdata,
   input  wire logic                  main_osc_ready,
   input  wire logic                  wdt_ctl_wr,
   input  wire logic                  wdt_int_en_wdata,
   input  wire logic                  wdt_rst_en_wdata,
   input  wire logic                  wdt_load_wr,
   input  wire logic [31:0]           watchdog_reload_value,
   input  wire logic                  wdt_int_clear,
   input  wire logic                  cause_clr_wr,
   input  wire rcs_pkg::rcs_cause_t   cause_clr_mask,
   output var  logic                  brownout_reset_enable,
   output var  logic                  bor_irq,
   output wire logic                  sys_reset,
   output wire logic                  core_restart,
   output var  rcs_pkg::rcs_prst_s    periph_rst,
   output wire logic [95:0]           peripheral_reset_regs,
   output var  logic [7:0]            regulator_trim,
   output var  rcs_pkg::rcs_clk_cfg_s clk_cfg,
   output var  logic [5:0]            osc_clk_en,
   output var  rcs_pkg::rcs_src_e     system_clock_main,
   output wire logic                  clk_switching,
   output var  logic                  wdt_irq,
   output var  logic [31:0]           wdt_count,
   output var  rcs_pkg::rcs_cause_t   reset_cause_reg
);
   import rcs_pkg::*;

   rcs_rst_st_e st_r;
   rcs_rst_st_e st_nxt;
   logic [7:0]  hold_r;
   logic [31:0] prst_r [3];
   logic [31:0] reload_r;
   logic        wdt_int_en_r;
   logic        wdt_rst_en_r;
   logic        switching_r;
   logic [3:0]  gap_r;
   rcs_src_e    tgt_r;

   // reset sources
   wire bor_rst_req  = bor_low & brownout_reset_enable;
   wire wdt_zero     = (wdt_count == 32'h0);
   wire wdt_timeout  = wdt_int_en_r & wdt_zero & ~sys_reset;
   wire wdt_rst_req  = wdt_timeout & wdt_irq & wdt_rst_en_r;
   wire any_req      = bor_rst_req | system_reset_request | wdt_rst_req;
   wire hold_done    = (hold_r == 8'h0);
   wire in_idle      = (st_r == RCS_ST_IDLE);

   // internal reset state walk: assert, stretch, restart
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         RCS_ST_IDLE:    if (any_req) st_nxt = RCS_ST_ASSERT;
         RCS_ST_ASSERT:  if (!bor_rst_req) st_nxt = RCS_ST_STRETCH;
         RCS_ST_STRETCH: begin
            if (bor_rst_req) st_nxt = RCS_ST_ASSERT;
            else if (hold_done) st_nxt = RCS_ST_BOOT;
         end
         RCS_ST_BOOT:    st_nxt = RCS_ST_IDLE;
         default:        st_nxt = RCS_ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_r   <= RCS_ST_IDLE;
         hold_r <= 8'h0;
      end else begin
         st_r   <= st_nxt;
         hold_r <= (st_nxt == RCS_ST_STRETCH && st_r != RCS_ST_STRETCH) ?
                   8'(`RCS_RST_HOLD_CYC - 1) : (hold_done ? hold_r : hold_r - 8'h1);
      end
   end

   // gray states: bit 0 marks reset asserted, boot is the fetch cycle
   assign sys_reset    = st_r[0];
   assign core_restart = (st_r == RCS_ST_BOOT);

   // brown-out control; power-on leaves reset generation off
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         brownout_reset_enable <= 1'b0;
         bor_irq               <= 1'b0;
      end else begin
         if (bor_ctl_wr) brownout_reset_enable <= bor_ctl_wdata;
         bor_irq <= bor_low & ~brownout_reset_enable;
      end
   end

   // cause bits: only events seen from idle; set wins over clear
   wire rcs_cause_t cause_set = {
      in_idle & system_reset_request & ~bor_rst_req,
      in_idle & wdt_rst_req & ~bor_rst_req & ~system_reset_request,
      in_idle & bor_rst_req,
      2'b00};
   wire rcs_cause_t cause_clr = cause_clr_wr ? cause_clr_mask : 5'h00;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) reset_cause_reg <= `RCS_CAUSE_RESET;
      else     reset_cause_reg <= (reset_cause_reg & ~cause_clr) | cause_set;
   end

   // peripheral resets: bit n of each word is the unit whose clock gate is bit n
   assign peripheral_reset_regs = {prst_r[2], prst_r[1], prst_r[0]};
   wire [95:0] prst_level = peripheral_reset_regs | {96{sys_reset}};

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 3; i++) prst_r[i] <= `RCS_PRST_RESET;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (sys_reset) prst_r[i] <= `RCS_PRST_RESET;
            else if (prst_wr[i]) prst_r[i] <= prst_wdata;
         end
      end
   end

   // held for as long as the bit is set, on every domain of the unit
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) periph_rst <= '1;
      else     periph_rst <= {prst_level, prst_level, prst_level};
   end

   // watchdog: first zero raises the interrupt and reloads, second may reset
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wdt_count    <= `RCS_WDT_RESET;
         reload_r     <= `RCS_WDT_RESET;
         wdt_int_en_r <= 1'b0;
         wdt_rst_en_r <= 1'b0;
         wdt_irq      <= 1'b0;
      end else if (sys_reset) begin
         wdt_count    <= `RCS_WDT_RESET;
         reload_r     <= `RCS_WDT_RESET;
         wdt_int_en_r <= 1'b0;
         wdt_rst_en_r <= 1'b0;
         wdt_irq      <= 1'b0;
      end else begin
         if (wdt_ctl_wr) begin
            wdt_int_en_r <= wdt_int_en_wdata;
            wdt_rst_en_r <= wdt_rst_en_wdata;
         end
         if (wdt_load_wr) begin
            reload_r  <= watchdog_reload_value;
            wdt_count <= watchdog_reload_value;
         end else if (wdt_timeout) begin
            wdt_count <= reload_r;
         end else if (wdt_int_en_r) begin
            wdt_count <= wdt_count - 32'h1;
         end
         // an expiry in the clear cycle keeps the interrupt
         wdt_irq <= (wdt_irq & ~wdt_int_clear) | wdt_timeout;
      end
   end

   // regulator trim, signed steps around nominal, out-of-range writes refused
   wire signed [7:0] trim_s = trim_wdata;
   wire trim_ok = (trim_s <= `RCS_TRIM_MAX_UP) && (trim_s >= `RCS_TRIM_MAX_DN);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) regulator_trim <= `RCS_TRIM_RESET;
      else if (trim_wr && trim_ok) regulator_trim <= trim_wdata;
   end

   // clock configuration; illegal combinations are refused so clk_cfg stays legal
   wire cfg_ok = clk_cfg_wdata.bypass ?
      (!clk_cfg_wdata.use_ext ||
       clk_cfg_wdata.extended_osc_source_select == `RCS_EXT_RTC) :
      (clk_cfg_wdata.osc_source_select == `RCS_OSC_MAIN && !clk_cfg_wdata.use_ext);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) clk_cfg <= `RCS_CLK_CFG_RESET;
      else if (clk_cfg_wr && cfg_ok) clk_cfg <= clk_cfg_wdata;
   end

   rcs_src_e osc_src;
   rcs_src_e want_src;
   always_comb begin
      case (clk_cfg.osc_source_select)
         `RCS_OSC_MAIN: osc_src = RCS_SRC_MAIN;
         `RCS_OSC_INT:  osc_src = RCS_SRC_INT;
         `RCS_OSC_INT4: osc_src = RCS_SRC_INT4;
         `RCS_OSC_30K:  osc_src = RCS_SRC_30K;
         default:       osc_src = RCS_SRC_INT;
      endcase
      if (!clk_cfg.bypass) want_src = RCS_SRC_PLL;
      else if (clk_cfg.use_ext) want_src = RCS_SRC_RTC;
      else want_src = osc_src;
   end

   // main oscillator and pll both hang on the crystal; wait for it to settle
   wire tgt_ready = ((tgt_r != RCS_SRC_MAIN) && (tgt_r != RCS_SRC_PLL)) || main_osc_ready;
   wire gap_done  = (gap_r == 4'h0);
   assign clk_switching = switching_r;

   // break before make: all gates off for the gap, then only the new one
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         system_clock_main <= RCS_SRC_INT;
         osc_clk_en        <= 6'h01;
         switching_r       <= 1'b0;
         gap_r             <= 4'h0;
         tgt_r             <= RCS_SRC_INT;
      end else if (!switching_r) begin
         if (want_src != system_clock_main) begin
            osc_clk_en  <= 6'h00;
            switching_r <= 1'b1;
            gap_r       <= 4'(`RCS_CLK_GAP_CYC);
            tgt_r       <= want_src;
         end
      end else if (!gap_done) begin
         gap_r <= gap_r - 4'h1;
      end else if (tgt_ready) begin
         system_clock_main <= tgt_r;
         osc_clk_en        <= 6'h01 << tgt_r;
         switching_r       <= 1'b0;
      end
   end

   // the pll reference range is software's duty; nothing here checks frequency

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   bor_gate_a: assert property ((in_idle && bor_low && !brownout_reset_enable &&
      !system_reset_request && !wdt_rst_req) |=> !sys_reset)
      else $error("brown-out reset without enable");
   bor_irq_a: assert property ((bor_low && !brownout_reset_enable) |=> bor_irq)
      else $error("brown-out interrupt missing");
   bor_hold_a: assert property ((sys_reset && bor_rst_req) |=> sys_reset [*2])
      else $error("reset dropped while supply low");
   bor_cause_a: assert property ((in_idle && bor_rst_req) |=>
      reset_cause_reg[`RCS_CAUSE_BOR] && sys_reset)
      else $error("brown-out cause not recorded");
   prst_level_a: assert property ((prst_wr[0] && in_idle) ##1 (!prst_wr[0] && in_idle) |=>
      periph_rst.dslp[31:0] == $past(prst_wdata, 2))
      else $error("peripheral reset level wrong");
   prst_domain_a: assert property ((periph_rst.run == periph_rst.slp) &&
      (periph_rst.run == periph_rst.dslp))
      else $error("clock domains of a unit differ");
   sysreq_hold_a: assert property ((in_idle && system_reset_request) |=> sys_reset [*8])
      else $error("system reset request too short");
   core_boot_a: assert property ($fell(sys_reset) |-> core_restart ##1 !core_restart)
      else $error("core restart not after release");
   wdt_second_a: assert property ((in_idle && wdt_rst_req && !bor_rst_req &&
      !system_reset_request) |=> sys_reset && reset_cause_reg[`RCS_CAUSE_WDT])
      else $error("second time-out did not reset");
   wdt_reload_a: assert property ((wdt_timeout && !wdt_load_wr) |=>
      wdt_irq && wdt_count == $past(reload_r))
      else $error("watchdog did not reload");
   clk_bbm_a: assert property ($changed(osc_clk_en) |->
      (osc_clk_en == 6'h00 || $past(osc_clk_en) == 6'h00))
      else $error("clock switch without gap");
   clk_onehot_a: assert property ($onehot0(osc_clk_en))
      else $error("more than one clock enabled");
   trim_range_a: assert property ($signed(regulator_trim) <= `RCS_TRIM_MAX_UP &&
      $signed(regulator_trim) >= `RCS_TRIM_MAX_DN)
      else $error("regulator trim out of range");
   cause_sticky_a: assert property (!cause_clr_wr |=>
      (reset_cause_reg & $past(reset_cause_reg)) == $past(reset_cause_reg))
      else $error("cause bit lost");

   bor_reset_c: cover property (in_idle && bor_rst_req ##[1:100] core_restart);
   wdt_reset_c: cover property (wdt_timeout ##[1:300] wdt_rst_req);
   pll_switch_c: cover property (switching_r ##[1:50] system_clock_main == RCS_SRC_PLL);
   prst_c: cover property (prst_wr[1] ##[1:20] !periph_rst.run[32]);
endmodule
`default_nettype wire

// *** testbench/rcs_top_test.sv ***
// self-checking bench for the reset and clock source control block
`include "rcs_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module rcs_top_test;
   import rcs_pkg::*;
   typedef struct packed {logic [6:0] cfg; rcs_src_e src;} rcs_row_s;
   logic         sys_clk, rst, bor_low, bor_ctl_wr, bor_ctl_wdata, system_reset_request;
   logic         trim_wr, clk_cfg_wr, main_osc_ready, wdt_ctl_wr, wdt_int_en_wdata;
   logic         wdt_rst_en_wdata, wdt_load_wr, wdt_int_clear, cause_clr_wr;
   logic         brownout_reset_enable, bor_irq, sys_reset, core_restart, clk_switching, wdt_irq;
   logic [2:0]   prst_wr;
   logic [31:0]  prst_wdata, watchdog_reload_value, wdt_count;
   logic [7:0]   trim_wdata, regulator_trim;
   logic [5:0]   osc_clk_en;
   logic [95:0]  peripheral_reset_regs;
   rcs_clk_cfg_s clk_cfg_wdata, clk_cfg;
   rcs_cause_t   cause_clr_mask, reset_cause_reg;
   rcs_prst_s    periph_rst;
   rcs_src_e     system_clock_main;
   int           bad_count, total_checks, cyc, n;
   logic [7:0]   trim_in [4] = '{8'h05, 8'h06, 8'hFB, 8'hFA};
   logic [7:0]   trim_ex [4] = '{8'h05, 8'h05, 8'hFB, 8'hFB};
   rcs_row_s     rows [6] = '{'{7'h60, RCS_SRC_INT4}, '{7'h70, RCS_SRC_30K},
                              '{7'h4F, RCS_SRC_RTC}, '{7'h40, RCS_SRC_MAIN},
                              '{7'h00, RCS_SRC_PLL}, '{7'h50, RCS_SRC_INT}};

   rcs_top i_rcs_top (.sys_clk, .rst, .bor_low, .bor_ctl_wr, .bor_ctl_wdata,
      .system_reset_request, .prst_wr, .prst_wdata, .trim_wr, .trim_wdata, .clk_cfg_wr,
      .clk_cfg_wdata, .main_osc_ready, .wdt_ctl_wr, .wdt_int_en_wdata, .wdt_rst_en_wdata,
      .wdt_load_wr, .watchdog_reload_value, .wdt_int_clear, .cause_clr_wr, .cause_clr_mask,
      .brownout_reset_enable, .bor_irq, .sys_reset, .core_restart, .periph_rst,
      .peripheral_reset_regs, .regulator_trim, .clk_cfg, .osc_clk_en, .system_clock_main,
      .clk_switching, .wdt_irq, .wdt_count, .reset_cause_reg);

   task automatic chk(logic [287:0] got, logic [287:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // waits for the internal reset, counts its length, then looks for the restart pulse
   task automatic see_reset(int exp_hi);
      int k;
      k = 0;
      @(negedge sys_clk);
      repeat (20) if (sys_reset !== 1'b1) @(negedge sys_clk);
      while (sys_reset === 1'b1 && k < 300) begin
         k++;
         @(negedge sys_clk);
      end
      if (exp_hi > 0) chk(k, exp_hi);
      chk(core_restart, 1'b1);
      @(negedge sys_clk);
      chk(core_restart, 1'b0);
   endtask

   // switch starts one cycle after the config lands, so skip two edges first
   task automatic wait_sw;
      int k;
      k = 0;
      repeat (2) @(negedge sys_clk);
      while (clk_switching === 1'b1 && k < 40) begin
         k++;
         @(negedge sys_clk);
      end
   endtask

   task automatic cfg_wr(logic [6:0] v);
      @(posedge sys_clk);
      clk_cfg_wdata <= v;
      clk_cfg_wr <= 1'b1;
      @(posedge sys_clk);
      clk_cfg_wr <= 1'b0;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // run ceiling well above the few hundred cycles the sequence needs
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         end_sim();
      end
   end

   initial begin
      {rst, bor_low, bor_ctl_wr, bor_ctl_wdata, system_reset_request, trim_wr} = '0;
      {clk_cfg_wr, wdt_ctl_wr, wdt_int_en_wdata, wdt_rst_en_wdata, wdt_load_wr} = '0;
      {wdt_int_clear, cause_clr_wr, prst_wr, prst_wdata, watchdog_reload_value} = '0;
      {trim_wdata, clk_cfg_wdata, cause_clr_mask} = '0;
      main_osc_ready = 1'b1;
      rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      chk(brownout_reset_enable, 1'b0);
      chk(reset_cause_reg, 5'h01);
      chk(system_clock_main, RCS_SRC_INT);
      chk(osc_clk_en, 6'h01);
      foreach (rows[i]) begin
         cfg_wr(rows[i].cfg);
         wait_sw();
         chk(clk_cfg, rows[i].cfg);
         chk(system_clock_main, rows[i].src);
         chk(osc_clk_en, 6'h01 << rows[i].src);
      end
      cfg_wr(7'h10);
      cfg_wr(7'h48);
      repeat (2) @(negedge sys_clk);
      chk(clk_cfg, 7'h50);
      @(posedge sys_clk);
      main_osc_ready <= 1'b0;
      cfg_wr(7'h40);
      repeat (20) @(negedge sys_clk);
      chk({clk_switching, osc_clk_en}, 7'h40);
      @(posedge sys_clk);
      main_osc_ready <= 1'b1;
      wait_sw();
      chk(system_clock_main, RCS_SRC_MAIN);
      foreach (trim_in[i]) begin
         @(posedge sys_clk);
         trim_wdata <= trim_in[i];
         trim_wr <= 1'b1;
         @(posedge sys_clk);
         trim_wr <= 1'b0;
         @(negedge sys_clk);
         chk(regulator_trim, trim_ex[i]);
      end
      @(posedge sys_clk);
      prst_wr <= 3'b010;
      prst_wdata <= 32'h0000_0020;
      @(posedge sys_clk);
      prst_wr <= 3'b000;
      repeat (10) @(negedge sys_clk);
      chk(peripheral_reset_regs, 96'h20 << 32);
      chk(periph_rst, {3{96'h20 << 32}});
      @(posedge sys_clk);
      prst_wr <= 3'b010;
      prst_wdata <= 32'h0;
      @(posedge sys_clk);
      prst_wr <= 3'b001;
      prst_wdata <= 32'h0000_00F0;
      @(posedge sys_clk);
      prst_wr <= 3'b000;
      repeat (3) @(negedge sys_clk);
      chk(periph_rst, {3{96'hF0}});
      @(posedge sys_clk);
      system_reset_request <= 1'b1;
      @(posedge sys_clk);
      system_reset_request <= 1'b0;
      // one assert cycle, then the full stretch
      see_reset(`RCS_RST_HOLD_CYC + 1);
      chk(peripheral_reset_regs, 96'h0);
      chk(reset_cause_reg, 5'h11);
      @(posedge sys_clk);
      bor_low <= 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({bor_irq, sys_reset}, 2'b10);
      @(posedge sys_clk);
      bor_low <= 1'b0;
      bor_ctl_wr <= 1'b1;
      bor_ctl_wdata <= 1'b1;
      @(posedge sys_clk);
      bor_ctl_wr <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk({brownout_reset_enable, bor_irq}, 2'b10);
      @(posedge sys_clk);
      bor_low <= 1'b1;
      repeat (60) @(negedge sys_clk);
      chk(sys_reset, 1'b1);
      @(posedge sys_clk);
      bor_low <= 1'b0;
      see_reset(0);
      chk(reset_cause_reg, 5'h15);
      @(posedge sys_clk);
      watchdog_reload_value <= 32'h0000_000A;
      wdt_load_wr <= 1'b1;
      @(posedge sys_clk);
      wdt_load_wr <= 1'b0;
      wdt_ctl_wr <= 1'b1;
      wdt_int_en_wdata <= 1'b1;
      @(posedge sys_clk);
      wdt_ctl_wr <= 1'b0;
      n = 0;
      while (wdt_irq !== 1'b1 && n < 30) begin
         @(negedge sys_clk);
         n++;
      end
      chk(wdt_irq, 1'b1);
      chk(wdt_count >= 32'd9 && wdt_count <= 32'd10, 1'b1);
      // clear must land away from a zero, else the next expiry re-arms it at once
      repeat (27) @(negedge sys_clk);
      chk(sys_reset, 1'b0);
      @(posedge sys_clk);
      wdt_int_clear <= 1'b1;
      wdt_ctl_wr <= 1'b1;
      wdt_rst_en_wdata <= 1'b1;
      @(posedge sys_clk);
      {wdt_int_clear, wdt_ctl_wr} <= 2'b00;
      @(negedge sys_clk);
      chk(wdt_irq, 1'b0);
      see_reset(`RCS_RST_HOLD_CYC + 1);
      chk({wdt_irq, reset_cause_reg}, 6'h1D);
      @(posedge sys_clk);
      cause_clr_wr <= 1'b1;
      cause_clr_mask <= 5'h08;
      @(posedge sys_clk);
      cause_clr_wr <= 1'b0;
      @(negedge sys_clk);
      chk(reset_cause_reg, 5'h15);
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      @(negedge sys_clk);
      chk({brownout_reset_enable, reset_cause_reg}, 6'h01);
      end_sim();
   end
endmodule
`default_nettype wire
